// ### verilog/qct_pkg.sv
// Shared constants and types of the quadrature and compare-match timer
package qct_pkg;

   // Channel and interrupt source counts
   localparam int unsigned QCT_NCH  = 2;
   localparam int unsigned QCT_NSRC = 5;

   // Interrupt source positions, highest priority first
   localparam int unsigned QCT_SRC_CH0_DN = 0;
   localparam int unsigned QCT_SRC_CH0_UP = 1;
   localparam int unsigned QCT_SRC_CH1_DN = 2;
   localparam int unsigned QCT_SRC_CH1_UP = 3;
   localparam int unsigned QCT_SRC_CMP    = 4;
   localparam logic [2:0]  QCT_NO_IRQ     = 3'h7;

   // Wait-state monitor bit positions; low nibble reads as zero
   localparam int unsigned QCT_MON_UP1  = 7;
   localparam int unsigned QCT_MON_DWN1 = 6;
   localparam int unsigned QCT_MON_UP0  = 5;
   localparam int unsigned QCT_MON_DWN0 = 4;

   // Normal-mode phase states, encoded from {A,B}
   localparam logic [1:0] QCT_PH_S1 = 2'h0;
   localparam logic [1:0] QCT_PH_S2 = 2'h1;
   localparam logic [1:0] QCT_PH_S3 = 2'h2;
   localparam logic [1:0] QCT_PH_S4 = 2'h3;

   // Channel 2 prescaler masks on the operating tick (/1, /4, /16, /64)
   localparam logic [5:0] QCT_PRE_MASK0 = 6'h00;
   localparam logic [5:0] QCT_PRE_MASK1 = 6'h03;
   localparam logic [5:0] QCT_PRE_MASK2 = 6'h0F;
   localparam logic [5:0] QCT_PRE_MASK3 = 6'h3F;

   // Values after reset
   localparam logic [7:0]  QCT_CNT8_RST   = 8'h00;
   localparam logic [15:0] QCT_CNT16_RST  = 16'h0000;
   localparam logic [15:0] QCT_COR_RST    = 16'hFFFF;
   localparam logic [7:0]  QCT_MON_RST    = 8'h00;

   typedef enum logic [1:0] {QCT_IDLE, QCT_WAIT_UP, QCT_WAIT_DN} qct_wait_t;

   // Software-written control bits, taken on the operating tick
   typedef struct packed {
      logic                count_speed_select;
      logic [2:0]          run;
      logic [1:0]          clk_select;
      logic                clear_on_match;
      logic [QCT_NSRC-1:0] irq_enable;
   } qct_ctrl_t;

   // Two phase inputs of one channel
   typedef struct packed {
      logic a;
      logic b;
   } qct_phase_t;

   typedef struct packed {
      logic                module_standby;
      logic                osc_prev;
      logic                half;
      logic [5:0]          pre;
      qct_ctrl_t           ctrl;
      qct_phase_t [1:0]    ph_prev;
      qct_wait_t [1:0]     wt;
      logic [1:0][7:0]     cnt8;
      logic [15:0]         cnt16;
      logic [15:0]         cor;
      logic [1:0]          pend8;
      logic [1:0][7:0]     wd8;
      logic                pend16;
      logic [15:0]         wd16;
      logic                pendcor;
      logic [15:0]         wdcor;
      logic [QCT_NSRC-1:0] flag;
      logic [QCT_NSRC-1:0] irq;
      logic [2:0]          irq_top;
      logic [7:0]          mon;
      logic                wakeup;
   } qct_state_t;

endpackage

// ### verilog/qct_timer.sv
// Two quadrature up/down counters and one 16-bit compare-match counter
`timescale 1ns/1ps
`default_nettype none

module qct_timer
   import qct_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   // Slow oscillator and module standby control
   input  wire logic                     slow_osc_input,
   input  wire logic                     standby_cancel,
   input  wire logic                     standby_enter,
   // Control bits
   input  wire qct_pkg::qct_ctrl_t       ctrl,
   // Counter and constant writes
   input  wire logic [1:0]               cnt8_wr,
   input  wire logic [7:0]               cnt8_wdata0,
   input  wire logic [7:0]               cnt8_wdata1,
   input  wire logic                     cnt16_wr,
   input  wire logic [15:0]              cnt16_wdata,
   input  wire logic                     cor_wr,
   input  wire logic [15:0]              cor_wdata,
   // Flag clears and system standby
   input  wire logic [4:0]               flag_clr,
   input  wire logic                     in_sw_standby,
   input  wire logic                     wakeup_clr,
   // Encoder phases
   input  wire qct_pkg::qct_phase_t      chan0_phase,
   input  wire qct_pkg::qct_phase_t      chan1_phase,
   // Counter state
   output logic [7:0]                    phase_counter_8bit0,
   output logic [7:0]                    phase_counter_8bit1,
   output logic [15:0]                   match_counter_16bit,
   output logic [15:0]                   match_constant,
   output logic [7:0]                    wait_state_monitor,
   output logic                          module_standby,
   // Status and interrupts
   output logic [4:0]                    timer_status,
   output logic                          chan0_down_irq,
   output logic                          chan0_up_irq,
   output logic                          chan1_down_irq,
   output logic                          chan1_up_irq,
   output logic                          compare_irq,
   output logic [2:0]                    irq_top,
   output logic                          standby_wakeup_flag
);
   import qct_pkg::*;

   qct_state_t s;
   qct_state_t next_s;

   logic       osc_rise;
   logic       op_tick;
   logic       cnt_tick;
   logic       hit;
   logic [1:0] inc;
   logic [1:0] dec;

   function automatic logic [1:0] phase_state(input qct_phase_t p);
      case ({p.a, p.b})
         2'h0:    phase_state = QCT_PH_S1;
         2'h2:    phase_state = QCT_PH_S2;
         2'h3:    phase_state = QCT_PH_S3;
         default: phase_state = QCT_PH_S4;
      endcase
   endfunction

   function automatic logic prescale_hit(input logic [1:0] sel, input logic [5:0] pre);
      logic [5:0] m;
      case (sel)
         2'h0:    m = QCT_PRE_MASK0;
         2'h1:    m = QCT_PRE_MASK1;
         2'h2:    m = QCT_PRE_MASK2;
         default: m = QCT_PRE_MASK3;
      endcase
      prescale_hit = ((pre & m) == m);
   endfunction

   function automatic logic [2:0] top_source(input logic [QCT_NSRC-1:0] req);
      top_source = QCT_NO_IRQ;
      for (int k = QCT_NSRC - 1; k >= 0; k--) begin
         if (req[k]) begin
            top_source = 3'(k);
         end
      end
   endfunction

   always_comb begin
      qct_phase_t cur;
      qct_phase_t prv;
      logic [1:0] cs;
      logic [1:0] ps;
      next_s   = s;
      cur      = '0;
      prv      = '0;
      cs       = QCT_PH_S1;
      ps       = QCT_PH_S1;
      inc      = 2'h0;
      dec      = 2'h0;
      hit      = 1'b0;
      cnt_tick = 1'b0;

      // Operating clock is the slow oscillator divided by two
      osc_rise        = slow_osc_input & ~s.osc_prev;
      next_s.osc_prev = slow_osc_input;
      if (osc_rise) begin
         next_s.half = ~s.half;
      end
      op_tick = osc_rise & s.half & ~s.module_standby;

      // Module standby gates access and counting
      if (standby_cancel) begin
         next_s.module_standby = 1'b0;
      end
      if (standby_enter) begin
         next_s.module_standby = 1'b1;
      end

      // Writes are held until the next operating tick, except one made in a tick cycle, which is lost
      if (!s.module_standby) begin
         for (int i = 0; i < QCT_NCH; i++) begin
            if (cnt8_wr[i]) begin
               next_s.pend8[i] = 1'b1;
               next_s.wd8[i]   = (i == 0) ? cnt8_wdata0 : cnt8_wdata1;
            end
         end
         if (cnt16_wr) begin
            next_s.pend16 = 1'b1;
            next_s.wd16   = cnt16_wdata;
         end
         if (cor_wr) begin
            next_s.pendcor = 1'b1;
            next_s.wdcor   = cor_wdata;
         end
      end

      if (op_tick) begin
         next_s.ctrl = ctrl;
         next_s.pre  = s.pre + 6'h01;
         for (int i = 0; i < QCT_NCH; i++) begin
            if (s.pend8[i]) begin
               next_s.cnt8[i] = s.wd8[i];
            end
         end
         if (s.pend16) begin
            next_s.cnt16 = s.wd16;
         end
         if (s.pendcor) begin
            next_s.cor = s.wdcor;
         end
         next_s.pend8   = 2'h0;
         next_s.pend16  = 1'b0;
         next_s.pendcor = 1'b0;
      end

      // Flags: hardware set below wins over a clear in the same cycle
      next_s.flag = s.flag & ~flag_clr;

      for (int i = 0; i < QCT_NCH; i++) begin
         cur               = (i == 0) ? chan0_phase : chan1_phase;
         prv               = s.ph_prev[i];
         next_s.ph_prev[i] = cur;
         cs                = phase_state(cur);
         ps                = phase_state(prv);
         if (s.ctrl.run[i] && !s.module_standby) begin
            if (s.ctrl.count_speed_select) begin
               next_s.wt[i] = QCT_IDLE;
               inc[i] = (cur.a & prv.b & ~cur.b) | (~cur.a & ~prv.b & cur.b)
                      | (~prv.a & cur.a & ~cur.b) | (prv.a & ~cur.a & cur.b);
               dec[i] = (cur.a & ~prv.b & cur.b) | (~cur.a & prv.b & ~cur.b)
                      | (~prv.a & cur.a & cur.b) | (prv.a & ~cur.a & ~cur.b);
            end else if (cs != ps) begin
               case (s.wt[i])
                  QCT_WAIT_UP: begin
                     if (ps == QCT_PH_S4 && cs == QCT_PH_S1) begin
                        inc[i]       = 1'b1;
                        next_s.wt[i] = QCT_IDLE;
                     end else if (ps == QCT_PH_S1 && cs == QCT_PH_S4) begin
                        next_s.wt[i] = QCT_WAIT_DN;
                     end
                  end
                  QCT_WAIT_DN: begin
                     if (ps == QCT_PH_S2 && cs == QCT_PH_S1) begin
                        dec[i]       = 1'b1;
                        next_s.wt[i] = QCT_IDLE;
                     end else if (ps == QCT_PH_S1 && cs == QCT_PH_S2) begin
                        next_s.wt[i] = QCT_WAIT_UP;
                     end
                  end
                  default: begin
                     if (ps == QCT_PH_S1 && cs == QCT_PH_S2) begin
                        next_s.wt[i] = QCT_WAIT_UP;
                     end else if (ps == QCT_PH_S1 && cs == QCT_PH_S4) begin
                        next_s.wt[i] = QCT_WAIT_DN;
                     end
                  end
               endcase
            end
         end
         // Both conditions in one cycle would need a half-step; treat as no move
         if (inc[i] && !dec[i]) begin
            next_s.cnt8[i]         = next_s.cnt8[i] + 8'h01;
            next_s.flag[2 * i + 1] = 1'b1;
         end else if (dec[i] && !inc[i]) begin
            next_s.cnt8[i]         = next_s.cnt8[i] - 8'h01;
            next_s.flag[2 * i]     = 1'b1;
         end
      end

      // Channel 2 counts on the prescaled operating tick
      cnt_tick = op_tick & prescale_hit(s.ctrl.clk_select, s.pre);
      if (s.ctrl.run[2] && cnt_tick) begin
         if (s.cnt16 == s.cor) begin
            hit                      = 1'b1;
            next_s.flag[QCT_SRC_CMP] = 1'b1;
            next_s.cnt16 = s.ctrl.clear_on_match ? QCT_CNT16_RST : s.cnt16 + 16'h0001;
         end else begin
            next_s.cnt16 = s.cnt16 + 16'h0001;
         end
      end
      if (s.ctrl.run[2] && !next_s.ctrl.run[2]) begin
         next_s.cnt16 = QCT_CNT16_RST;
      end

      // Each source has its own enable and request line
      next_s.irq     = next_s.flag & next_s.ctrl.irq_enable;
      next_s.irq_top = top_source(next_s.irq);

      next_s.wakeup = s.wakeup & ~wakeup_clr;
      if (in_sw_standby && (|next_s.irq)) begin
         next_s.wakeup = 1'b1;
      end

      next_s.mon = QCT_MON_RST;
      if (!next_s.ctrl.count_speed_select) begin
         next_s.mon[QCT_MON_UP1]  = (next_s.wt[1] == QCT_WAIT_UP);
         next_s.mon[QCT_MON_DWN1] = (next_s.wt[1] == QCT_WAIT_DN);
         next_s.mon[QCT_MON_UP0]  = (next_s.wt[0] == QCT_WAIT_UP);
         next_s.mon[QCT_MON_DWN0] = (next_s.wt[0] == QCT_WAIT_DN);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s                <= '0;
         s.module_standby <= 1'b1;
         s.cor            <= QCT_COR_RST;
         s.cnt8           <= {QCT_CNT8_RST, QCT_CNT8_RST};
         s.cnt16          <= QCT_CNT16_RST;
         s.wt[0]          <= QCT_IDLE;
         s.wt[1]          <= QCT_IDLE;
         s.irq_top        <= QCT_NO_IRQ;
         s.mon            <= QCT_MON_RST;
      end else begin
         s <= next_s;
      end
   end

   assign phase_counter_8bit0 = s.cnt8[0];
   assign phase_counter_8bit1 = s.cnt8[1];
   assign match_counter_16bit = s.cnt16;
   assign match_constant      = s.cor;
   assign wait_state_monitor  = s.mon;
   assign module_standby      = s.module_standby;
   assign timer_status        = s.flag;
   assign chan0_down_irq      = s.irq[QCT_SRC_CH0_DN];
   assign chan0_up_irq        = s.irq[QCT_SRC_CH0_UP];
   assign chan1_down_irq      = s.irq[QCT_SRC_CH1_DN];
   assign chan1_up_irq        = s.irq[QCT_SRC_CH1_UP];
   assign compare_irq         = s.irq[QCT_SRC_CMP];
   assign irq_top             = s.irq_top;
   assign standby_wakeup_flag = s.wakeup;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_arm_up0;
      !s.ctrl.count_speed_select && s.ctrl.run[0] && !s.module_standby
      && s.ph_prev[0] == 2'h0 && chan0_phase == 2'h2 && !op_tick;
   endsequence

   sequence s_fire_up0;
      s.wt[0] == QCT_WAIT_UP && chan0_phase == 2'h0 && s.ph_prev[0] == 2'h1
      && !s.ctrl.count_speed_select && s.ctrl.run[0] && !s.module_standby;
   endsequence

   a_arm_up_wait: assert property (s_arm_up0 |=> wait_state_monitor[QCT_MON_UP0])
      else $error("increment wait not armed");
   a_up_count: assert property ((s_fire_up0 and !op_tick) |=>
      phase_counter_8bit0 == $past(phase_counter_8bit0) + 8'h01 && timer_status[QCT_SRC_CH0_UP])
      else $error("armed increment did not count");
   a_hs_monitor_zero: assert property (s.ctrl.count_speed_select |-> wait_state_monitor == 8'h00)
      else $error("monitor not zero in high-speed mode");
   a_match_flag: assert property (hit |=> timer_status[QCT_SRC_CMP])
      else $error("match did not set flag");
   a_match_clear: assert property (hit && s.ctrl.clear_on_match && next_s.ctrl.run[2]
      |=> match_counter_16bit == 16'h0000)
      else $error("counter not cleared on match");
   a_run_clear: assert property ($fell(s.ctrl.run[2]) |-> match_counter_16bit == 16'h0000)
      else $error("halting channel 2 did not clear counter");
   a_cmp_irq_gate: assert property (compare_irq |-> s.ctrl.irq_enable[QCT_SRC_CMP]
      && timer_status[QCT_SRC_CMP])
      else $error("compare request without enable");
   a_standby_hold: assert property (module_standby && !standby_cancel |=>
      $stable(match_counter_16bit) && $stable(phase_counter_8bit0))
      else $error("counting during module standby");
   a_wakeup_set: assert property (in_sw_standby && (|next_s.irq) |=> standby_wakeup_flag)
      else $error("wakeup flag not set");
   a_write_tick: assert property (!op_tick && !(s.ctrl.run[2] && !next_s.ctrl.run[2]) && !cnt_tick
      |=> $stable(match_counter_16bit))
      else $error("channel 2 counter changed off the tick");
   a_top_prio: assert property (chan0_down_irq |-> irq_top == 3'h0)
      else $error("priority order wrong");

endmodule

`default_nettype wire

// ### verification/qct_encoder.sv
// Two-phase rotary encoder model driving one channel's phase inputs
`timescale 1ns/1ps
`default_nettype none

module qct_encoder
   import qct_pkg::*;
(
   // Clock
   input  wire logic                mclk,
   // Encoder phases
   output var  qct_pkg::qct_phase_t phase
);
   import qct_pkg::*;

   initial phase = '0;

   // Pin levels {a,b} of each phase state
   function automatic qct_phase_t level_of(input logic [1:0] st);
      case (st)
         QCT_PH_S1: level_of = 2'h0;
         QCT_PH_S2: level_of = 2'h2;
         QCT_PH_S3: level_of = 2'h3;
         default:   level_of = 2'h1;
      endcase
   endfunction

   // One level change just after an edge, then held; hold 0 moves every cycle
   task automatic set_level(input qct_phase_t lv, input int unsigned hold);
      @(posedge mclk);
      phase <= lv;
      repeat (hold) @(posedge mclk);
   endtask

   // Move to a phase state, given by its state code
   task automatic move(input logic [1:0] to, input int unsigned hold);
      set_level(level_of(to), hold);
   endtask

   // One full detent, ending back in the reference state
   task automatic turn(input logic fwd, input int unsigned hold);
      if (fwd) begin
         move(QCT_PH_S2, hold);
         move(QCT_PH_S3, hold);
         move(QCT_PH_S4, hold);
      end else begin
         move(QCT_PH_S4, hold);
         move(QCT_PH_S3, hold);
         move(QCT_PH_S2, hold);
      end
      move(QCT_PH_S1, hold);
   endtask
endmodule

`default_nettype wire

// ### verification/quadrature_compare_timer_bench.sv
// Self-checking bench of the quadrature and compare-match timer
`timescale 1ns/1ps
`default_nettype none

module quadrature_compare_timer_bench;
   import qct_pkg::*;

   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic              slow_osc_input = 1'b0;
   logic [1:0]        osc_cnt = 2'h0;
   logic              standby_cancel = 1'b0;
   logic              standby_enter = 1'b0;
   qct_ctrl_t         ctrl = '0;
   logic [1:0]        cnt8_wr = 2'h0;
   logic [7:0]        cnt8_wdata0 = 8'h00;
   logic [7:0]        cnt8_wdata1 = 8'h00;
   logic              cnt16_wr = 1'b0;
   logic [15:0]       cnt16_wdata = 16'h0000;
   logic              cor_wr = 1'b0;
   logic [15:0]       cor_wdata = 16'h0000;
   logic [4:0]        flag_clr = 5'h00;
   logic              in_sw_standby = 1'b0;
   logic              wakeup_clr = 1'b0;
   qct_phase_t        ph0;
   qct_phase_t        ph1;
   logic [7:0]        cnt0;
   logic [7:0]        cnt1;
   logic [15:0]       match_counter_16bit;
   logic [15:0]       match_constant;
   logic [7:0]        wait_state_monitor;
   logic              module_standby;
   logic [4:0]        timer_status;
   wire  logic [4:0]  irqs;
   logic [2:0]        irq_top;
   logic              standby_wakeup_flag;
   int                failures = 0;
   int                compares = 0;

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   // Slow oscillator toggles every 4 cycles, so the operating tick comes every 16
   always @(posedge mclk) begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_cnt == 2'h3) slow_osc_input <= ~slow_osc_input;
   end

   qct_encoder u_qct_encoder0 (.mclk(mclk), .phase(ph0));
   qct_encoder u_qct_encoder1 (.mclk(mclk), .phase(ph1));

   qct_timer u_qct_timer (
      .mclk(mclk), .rst_n(rst_n), .slow_osc_input(slow_osc_input),
      .standby_cancel(standby_cancel), .standby_enter(standby_enter), .ctrl(ctrl),
      .cnt8_wr(cnt8_wr), .cnt8_wdata0(cnt8_wdata0), .cnt8_wdata1(cnt8_wdata1),
      .cnt16_wr(cnt16_wr), .cnt16_wdata(cnt16_wdata), .cor_wr(cor_wr), .cor_wdata(cor_wdata),
      .flag_clr(flag_clr), .in_sw_standby(in_sw_standby), .wakeup_clr(wakeup_clr),
      .chan0_phase(ph0), .chan1_phase(ph1),
      .phase_counter_8bit0(cnt0), .phase_counter_8bit1(cnt1),
      .match_counter_16bit(match_counter_16bit), .match_constant(match_constant),
      .wait_state_monitor(wait_state_monitor), .module_standby(module_standby),
      .timer_status(timer_status), .chan0_down_irq(irqs[0]), .chan0_up_irq(irqs[1]),
      .chan1_down_irq(irqs[2]), .chan1_up_irq(irqs[3]), .compare_irq(irqs[4]),
      .irq_top(irq_top), .standby_wakeup_flag(standby_wakeup_flag));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Outputs are looked at on the falling edge, clear of the launching edge
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   // Long enough for two operating ticks to pick the value up
   task automatic set_ctrl(input qct_ctrl_t c);
      @(posedge mclk);
      ctrl <= c;
      settle(40);
   endtask

   task automatic clr(input logic [4:0] m);
      @(posedge mclk);
      flag_clr <= m;
      @(posedge mclk);
      flag_clr <= 5'h00;
      settle(1);
   endtask

   task automatic wait_change(output int n);
      logic [15:0] v;
      v = match_counter_16bit;
      n = 0;
      while (match_counter_16bit === v && n < 2000) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic wait_match(output int n);
      n = 0;
      while (timer_status[QCT_SRC_CMP] !== 1'b1 && n < 600) begin
         @(negedge mclk);
         n++;
      end
      check("match wait", 16'(n < 600), 16'h1);
   endtask

   task automatic t_reset;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      cor_wr <= 1'b1;
      cor_wdata <= 16'h0005;
      @(posedge mclk);
      cor_wr <= 1'b0;
      settle(40);
      check("standby", module_standby, 16'h1);
      check("constant", match_constant, 16'hFFFF);
      check("counter16", match_counter_16bit, 16'h0000);
      check("counters8", {cnt1, cnt0}, 16'h0000);
      check("monitor", wait_state_monitor, 16'h0000);
      check("status", timer_status, 16'h0000);
      check("irq top", irq_top, QCT_NO_IRQ);
      @(posedge mclk);
      standby_cancel <= 1'b1;
      @(posedge mclk);
      standby_cancel <= 1'b0;
      settle(2);
      check("standby", module_standby, 16'h0);
   endtask

   task automatic t_normal;
      qct_ctrl_t c;
      c = '0;
      c.run = 3'h3;
      c.irq_enable = 5'h1F;
      set_ctrl(c);
      u_qct_encoder0.move(QCT_PH_S2, 3);
      settle(1);
      check("up wait 0", wait_state_monitor[QCT_MON_UP0], 16'h1);
      u_qct_encoder0.move(QCT_PH_S3, 3);
      u_qct_encoder0.move(QCT_PH_S4, 3);
      u_qct_encoder0.move(QCT_PH_S1, 3);
      settle(1);
      check("count 0", cnt0, 16'h0001);
      check("up irq 0", irqs, 16'h0002);
      u_qct_encoder1.turn(1'b0, 3);
      settle(1);
      check("dn wait 1", wait_state_monitor[QCT_MON_DWN1], 16'h0);
      check("count 1", cnt1, 16'h00FF);
      check("status", timer_status, 16'h0006);
      check("top", irq_top, 16'h0001);
      clr(5'h02);
      check("top", irq_top, 16'h0002);
      c.irq_enable = 5'h1B;
      set_ctrl(c);
      check("masked irq", irqs, 16'h0000);
      check("masked flag", timer_status, 16'h0004);
      c.irq_enable = 5'h1F;
      set_ctrl(c);
      clr(5'h1F);
   endtask

   task automatic t_reroute;
      u_qct_encoder0.move(QCT_PH_S2, 3);
      u_qct_encoder0.move(QCT_PH_S1, 3);
      u_qct_encoder0.move(QCT_PH_S4, 3);
      settle(1);
      check("wait dn0", wait_state_monitor[5:4], 16'h1);
      u_qct_encoder0.move(QCT_PH_S1, 3);
      u_qct_encoder0.move(QCT_PH_S2, 3);
      settle(1);
      check("wait up0", wait_state_monitor[5:4], 16'h2);
      u_qct_encoder0.move(QCT_PH_S1, 3);
   endtask

   task automatic t_high_speed;
      qct_ctrl_t   c;
      logic [15:0] walk;
      // Single-pin steps from 00, alternating up and down over all eight cases
      walk = 16'h74B8;
      c = '0;
      c.irq_enable = 5'h1F;
      set_ctrl(c);
      @(posedge mclk);
      cnt8_wr <= 2'h3;
      cnt8_wdata0 <= 8'h80;
      cnt8_wdata1 <= 8'h40;
      @(posedge mclk);
      cnt8_wr <= 2'h0;
      settle(40);
      check("loaded", {cnt1, cnt0}, 16'h4080);
      c.count_speed_select = 1'b1;
      c.run = 3'h3;
      set_ctrl(c);
      clr(5'h1F);
      for (int i = 0; i < 8; i++) begin
         u_qct_encoder0.set_level(walk[15 - 2 * i -: 2], 1);
         settle(1);
         check("fast count", cnt0, (i % 2 == 0) ? 16'h0081 : 16'h0080);
         check("fast monitor", wait_state_monitor, 16'h0000);
      end
      check("fast flags", timer_status[1:0], 16'h3);
      clr(5'h1F);
   endtask

   task automatic t_compare;
      qct_ctrl_t c;
      int        n;
      c = '0;
      c.clear_on_match = 1'b1;
      c.irq_enable = 5'h10;
      set_ctrl(c);
      @(posedge mclk);
      cor_wr <= 1'b1;
      cor_wdata <= 16'h0003;
      @(posedge mclk);
      cor_wr <= 1'b0;
      settle(40);
      check("constant", match_constant, 16'h0003);
      c.run = 3'h4;
      @(posedge mclk);
      ctrl <= c;
      wait_match(n);
      check("cleared", match_counter_16bit, 16'h0000);
      check("cmp irq", irqs[QCT_SRC_CMP], 16'h1);
      check("top", irq_top, 16'h0004);
      settle(16);
      check("resumed", match_counter_16bit, 16'h0001);
      c.irq_enable = 5'h00;
      set_ctrl(c);
      check("cmp masked", irqs[QCT_SRC_CMP], 16'h0);
      c.run = 3'h0;
      set_ctrl(c);
      check("halt clear", match_counter_16bit, 16'h0000);
      clr(5'h1F);
      c.clear_on_match = 1'b0;
      set_ctrl(c);
      c.run = 3'h4;
      @(posedge mclk);
      ctrl <= c;
      wait_match(n);
      check("no clear", match_counter_16bit, 16'h0004);
      c.run = 3'h0;
      set_ctrl(c);
      clr(5'h1F);
   endtask

   task automatic t_prescale;
      qct_ctrl_t c;
      int        n;
      c = '0;
      for (int sel = 0; sel < 4; sel++) begin
         c.run = 3'h0;
         c.clk_select = 2'(sel);
         set_ctrl(c);
         c.run = 3'h4;
         set_ctrl(c);
         wait_change(n);
         wait_change(n);
         check("count period", 16'(n), 16'(16 << (2 * sel)));
      end
      c.run = 3'h0;
      set_ctrl(c);
      clr(5'h1F);
   endtask

   task automatic t_wakeup;
      qct_ctrl_t c;
      c = '0;
      c.run = 3'h3;
      c.irq_enable = 5'h1F;
      set_ctrl(c);
      check("no wakeup", standby_wakeup_flag, 16'h0);
      @(posedge mclk);
      in_sw_standby <= 1'b1;
      u_qct_encoder1.turn(1'b1, 0);
      settle(2);
      check("count 1", cnt1, 16'h0041);
      check("wakeup", standby_wakeup_flag, 16'h1);
      @(posedge mclk);
      in_sw_standby <= 1'b0;
      wakeup_clr <= 1'b1;
      @(posedge mclk);
      wakeup_clr <= 1'b0;
      standby_enter <= 1'b1;
      @(posedge mclk);
      standby_enter <= 1'b0;
      settle(2);
      check("wakeup clr", standby_wakeup_flag, 16'h0);
      check("standby", module_standby, 16'h1);
   endtask

   // Whole run is some 4,000 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      give_verdict();
   end

   initial begin
      t_reset();
      t_normal();
      t_reroute();
      t_high_speed();
      t_compare();
      t_prescale();
      t_wakeup();
      give_verdict();
   end
endmodule

`default_nettype wire
